/* hw/pwm_timer_pkg.sv */
// Constants for the four-channel PWM timer with input capture
package pwm_timer_pkg;
    localparam int NUM_CH = 4;
    localparam int NUM_PAIR = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] PRESCALE_OFF = 8'h00;
    localparam logic [7:0] DIVIDER_OFF = 8'h04;
    localparam logic [7:0] CONTROL_OFF = 8'h08;
    localparam logic [7:0] CH_BASE_OFF = 8'h0C;
    localparam logic [7:0] CH_STRIDE = 8'h0C;
    localparam logic [7:0] PERIOD_SUB = 8'h00;
    localparam logic [7:0] COMPARE_SUB = 8'h04;
    localparam logic [7:0] READBACK_SUB = 8'h08;
    localparam logic [7:0] INT_ENABLE_OFF = 8'h40;
    localparam logic [7:0] INT_FLAG_OFF = 8'h44;
    localparam logic [7:0] CAPCTL_OFF = 8'h50;
    localparam logic [7:0] CAPCTL_STRIDE = 8'h04;
    localparam logic [7:0] LATCH_BASE_OFF = 8'h58;
    localparam logic [7:0] LATCH_STRIDE = 8'h08;
    localparam logic [7:0] FALL_SUB = 8'h04;
    localparam logic [7:0] CAPEN_OFF = 8'h78;
    localparam logic [7:0] OUTEN_OFF = 8'h7C;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int PRE_FIELD_W = 8;
    localparam int PRE_STRIDE = 8;
    localparam int DZ_POS = 16;
    localparam int DIV_FIELD_W = 3;
    localparam int DIV_STRIDE = 4;
    localparam int CTL_STRIDE = 8;
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_INV_BIT = 2;
    localparam int CTL_MODE_BIT = 3;
    localparam int CTL_DZ_BIT = 4;
    localparam int CAP_STRIDE = 16;
    localparam int CAP_RISE_IE_BIT = 1;
    localparam int CAP_FALL_IE_BIT = 2;
    localparam int CAP_FLAG_BIT = 4;
    localparam int CAP_RISE_FLAG_BIT = 6;
    localparam int CAP_FALL_FLAG_BIT = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Divider select codes and reset value
    localparam logic [2:0] DIV_SEL_2 = 3'h0;
    localparam logic [2:0] DIV_SEL_4 = 3'h1;
    localparam logic [2:0] DIV_SEL_8 = 3'h2;
    localparam logic [2:0] DIV_SEL_16 = 3'h3;
    localparam logic [2:0] DIV_SEL_1 = 3'h4;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage

/* hw/pwm_timer_with_capture.sv */
// Four-channel PWM timer group with dead-zone pairs and input capture
//
// Summary of operation
// - Frequency is clock over prescale plus one, divider, period plus one
// - Compare at or above period keeps output high
// - Low period-compare ticks, high compare plus one
// - New period takes effect next period in auto-reload mode
// - Counter readback returns live down counter
// - Mode bit zero one-shot, one auto-reload
// - Mode change clears period and compare
// - One-shot end clears values, holds counter
// - One-shot non-zero period write restarts counting
// - Auto-reload reloads period at zero
// - Zero period holds the counter
// - Compare write applies from next period
// - Dead zone delays paired rising edges
// - Capture latches counter on input edges
// - Separate rise and fall capture interrupt enables
// - Capture interrupt reloads counter from period
// - Pulse widths follow from period and latches
// - Channel interrupts merged per group line
// - Clearing run enable stops output at once; an odd dead-zone output follows the even run bit
// - Counter reaching zero sets channel flag
// - Dead-zone pair complementary, even timer drives
// - Prescaler divides by value plus one, zero stops
//
// The address map and the address-and-strobe port are this design's own decisions.
module pwm_timer_with_capture (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    // Channel pins
    output logic [3:0] pwm_out,
    output logic [3:0] pwm_oe,
    input wire logic [3:0] cap_in,
    // Interrupt
    output logic group_a_interrupt
);

    ////////////////////////////////////////////////////////////////////////////
    // Shared registers
    logic [31:0] prescale_control_reg;
    logic [31:0] divider_select_reg;
    logic [31:0] channel_control_reg;
    logic [3:0] interrupt_enable_set_reg;
    logic [3:0] period_flag_reg;
    logic [3:0] capture_input_enable_reg;
    logic [3:0] pin_output_enable_reg;
    logic [3:0] rise_ie_reg;
    logic [3:0] fall_ie_reg;
    logic [3:0] capture_flag_reg;
    logic [3:0] rise_flag_reg;
    logic [3:0] fall_flag_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // Per-channel state
    logic [15:0] period_reload_value_reg [pwm_timer_pkg::NUM_CH];
    logic [15:0] compare_value_reg [pwm_timer_pkg::NUM_CH];
    logic [15:0] period_act_reg [pwm_timer_pkg::NUM_CH];
    logic [15:0] compare_act_reg [pwm_timer_pkg::NUM_CH];
    logic [15:0] count_reg [pwm_timer_pkg::NUM_CH];
    logic [15:0] rise_capture_latch_reg [pwm_timer_pkg::NUM_CH];
    logic [15:0] fall_capture_latch_reg [pwm_timer_pkg::NUM_CH];
    logic [3:0] div_cnt_reg [pwm_timer_pkg::NUM_CH];
    logic [7:0] dz_cnt_reg [pwm_timer_pkg::NUM_CH];
    logic [7:0] pre_cnt_reg [pwm_timer_pkg::NUM_PAIR];
    logic [3:0] tick;
    logic [3:0] zero_evt;
    logic [3:0] raw_pwm;
    logic [3:0] run;
    logic [3:0] mode;
    logic [3:0] mode_flip;
    logic [3:0] rise_evt;
    logic [3:0] fall_evt;
    logic [3:0] cap_irq_evt;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] sync3_reg;
    logic [3:0] out_reg;
    logic [1:0] pre_tick;

    logic ctl_wr;

    function automatic logic [7:0] ch_addr(input int ch, input logic [7:0] sub);
        return 8'(pwm_timer_pkg::CH_BASE_OFF + ch * pwm_timer_pkg::CH_STRIDE) + sub;
    endfunction

    function automatic logic [7:0] latch_addr(input int ch, input logic [7:0] sub);
        return 8'(pwm_timer_pkg::LATCH_BASE_OFF + ch * pwm_timer_pkg::LATCH_STRIDE) + sub;
    endfunction

    // Divide factor minus one, as a terminal count for the divider
    function automatic logic [3:0] div_last(input logic [2:0] sel);
        case (sel)
            pwm_timer_pkg::DIV_SEL_1: return 4'h0;
            pwm_timer_pkg::DIV_SEL_2: return 4'h1;
            pwm_timer_pkg::DIV_SEL_4: return 4'h3;
            pwm_timer_pkg::DIV_SEL_8: return 4'h7;
            pwm_timer_pkg::DIV_SEL_16: return 4'hF;
            default: return 4'h1;
        endcase
    endfunction

    assign ctl_wr = wr_en && (addr == pwm_timer_pkg::CONTROL_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // Shared register writes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prescale_control_reg <= pwm_timer_pkg::REG_RESET;
            divider_select_reg <= pwm_timer_pkg::REG_RESET;
            channel_control_reg <= pwm_timer_pkg::REG_RESET;
            interrupt_enable_set_reg <= 4'h0;
            capture_input_enable_reg <= 4'h0;
            pin_output_enable_reg <= 4'h0;
        end else if (wr_en) begin
            case (addr)
                pwm_timer_pkg::PRESCALE_OFF: prescale_control_reg <= wdata;
                pwm_timer_pkg::DIVIDER_OFF: divider_select_reg <= wdata & 32'h0000_7777;
                pwm_timer_pkg::CONTROL_OFF: channel_control_reg <= wdata & 32'h0D0D_0D3D;
                pwm_timer_pkg::INT_ENABLE_OFF: interrupt_enable_set_reg <= wdata[3:0];
                pwm_timer_pkg::CAPEN_OFF: capture_input_enable_reg <= wdata[3:0];
                pwm_timer_pkg::OUTEN_OFF: pin_output_enable_reg <= wdata[3:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescalers, one per pair
    for (genvar p = 0; p < pwm_timer_pkg::NUM_PAIR; p++) begin : g_pre
        logic [7:0] pre_val;
        assign pre_val = prescale_control_reg[p * pwm_timer_pkg::PRE_STRIDE +: 8];
        assign pre_tick[p] = (pre_val != 8'h00) && (pre_cnt_reg[p] == pre_val);

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                pre_cnt_reg[p] <= 8'h00;
            end else if (pre_val == 8'h00 || pre_cnt_reg[p] >= pre_val) begin
                pre_cnt_reg[p] <= 8'h00;
            end else begin
                pre_cnt_reg[p] <= pre_cnt_reg[p] + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and edge detect
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            sync3_reg <= 4'h0;
        end else begin
            sync1_reg <= cap_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign rise_evt = capture_input_enable_reg & sync2_reg & ~sync3_reg;
    assign fall_evt = capture_input_enable_reg & ~sync2_reg & sync3_reg;
    assign cap_irq_evt = (rise_evt & rise_ie_reg) | (fall_evt & fall_ie_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Channels
    for (genvar i = 0; i < pwm_timer_pkg::NUM_CH; i++) begin : g_ch
        localparam int CB = i * pwm_timer_pkg::CTL_STRIDE;
        localparam int PAIR = i / 2;
        localparam int KB = (i % 2) * pwm_timer_pkg::CAP_STRIDE;
        localparam logic [7:0] CAP_ADDR = 8'(pwm_timer_pkg::CAPCTL_OFF
            + PAIR * pwm_timer_pkg::CAPCTL_STRIDE);
        logic per_wr;
        logic cmp_wr;
        logic cap_wr;
        logic dz_on;
        logic target;
        logic [7:0] dz_len;

        assign run[i] = channel_control_reg[CB + pwm_timer_pkg::CTL_EN_BIT];
        assign mode[i] = channel_control_reg[CB + pwm_timer_pkg::CTL_MODE_BIT];
        assign mode_flip[i] = ctl_wr && (wdata[CB + pwm_timer_pkg::CTL_MODE_BIT] != mode[i]);
        assign per_wr = wr_en && (addr == ch_addr(i, pwm_timer_pkg::PERIOD_SUB));
        assign cmp_wr = wr_en && (addr == ch_addr(i, pwm_timer_pkg::COMPARE_SUB));
        assign cap_wr = wr_en && (addr == CAP_ADDR);
        assign tick[i] = pre_tick[PAIR] && (div_cnt_reg[i] == div_last(
            divider_select_reg[i * pwm_timer_pkg::DIV_STRIDE +: pwm_timer_pkg::DIV_FIELD_W]));
        assign zero_evt[i] = run[i] && tick[i] && (count_reg[i] == 16'h0001);

        // Clock divider on prescaler pulses
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                div_cnt_reg[i] <= 4'h0;
            end else if (tick[i]) begin
                div_cnt_reg[i] <= 4'h0;
            end else if (pre_tick[PAIR]) begin
                div_cnt_reg[i] <= div_cnt_reg[i] + 4'h1;
            end
        end

        // Buffered period and compare; a write wins over a hardware clear
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                period_reload_value_reg[i] <= 16'h0000;
                compare_value_reg[i] <= 16'h0000;
            end else if (mode_flip[i]) begin
                period_reload_value_reg[i] <= 16'h0000;
                compare_value_reg[i] <= 16'h0000;
            end else begin
                if (per_wr) begin
                    period_reload_value_reg[i] <= wdata[15:0];
                end else if (zero_evt[i] && !mode[i]) begin
                    period_reload_value_reg[i] <= 16'h0000;
                end
                if (cmp_wr) begin
                    compare_value_reg[i] <= wdata[15:0];
                end else if (zero_evt[i] && !mode[i]) begin
                    compare_value_reg[i] <= 16'h0000;
                end
            end
        end

        // Down counter and active period/compare
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                count_reg[i] <= 16'h0000;
                period_act_reg[i] <= 16'h0000;
                compare_act_reg[i] <= 16'h0000;
            end else if (per_wr && !mode[i] && wdata[15:0] != 16'h0000) begin
                count_reg[i] <= wdata[15:0];
                period_act_reg[i] <= wdata[15:0];
                compare_act_reg[i] <= compare_value_reg[i];
            end else if (cap_irq_evt[i]) begin
                count_reg[i] <= period_reload_value_reg[i];
            end else if (run[i] && tick[i]) begin
                if (count_reg[i] != 16'h0000) begin
                    count_reg[i] <= count_reg[i] - 16'h0001;
                    if (zero_evt[i] && !mode[i]) begin
                        period_act_reg[i] <= 16'h0000;
                    end
                end else if (mode[i] && period_reload_value_reg[i] != 16'h0000) begin
                    count_reg[i] <= period_reload_value_reg[i];
                    period_act_reg[i] <= period_reload_value_reg[i];
                    compare_act_reg[i] <= compare_value_reg[i];
                end else if (mode[i]) begin
                    period_act_reg[i] <= 16'h0000;
                end
            end
        end

        // High while count at or below compare, so high width is compare+1
        assign raw_pwm[i] = run[i] && (period_act_reg[i] != 16'h0000)
            && (count_reg[i] <= compare_act_reg[i]);

        // Capture latches and flags; an edge wins over a clear
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                rise_capture_latch_reg[i] <= 16'h0000;
                fall_capture_latch_reg[i] <= 16'h0000;
                rise_ie_reg[i] <= 1'b0;
                fall_ie_reg[i] <= 1'b0;
                rise_flag_reg[i] <= 1'b0;
                fall_flag_reg[i] <= 1'b0;
                capture_flag_reg[i] <= 1'b0;
            end else begin
                if (rise_evt[i]) begin
                    rise_capture_latch_reg[i] <= count_reg[i];
                end
                if (fall_evt[i]) begin
                    fall_capture_latch_reg[i] <= count_reg[i];
                end
                if (cap_wr) begin
                    rise_ie_reg[i] <= wdata[KB + pwm_timer_pkg::CAP_RISE_IE_BIT];
                    fall_ie_reg[i] <= wdata[KB + pwm_timer_pkg::CAP_FALL_IE_BIT];
                end
                rise_flag_reg[i] <= rise_evt[i] | (rise_flag_reg[i]
                    & ~(cap_wr & wdata[KB + pwm_timer_pkg::CAP_RISE_FLAG_BIT]));
                fall_flag_reg[i] <= fall_evt[i] | (fall_flag_reg[i]
                    & ~(cap_wr & wdata[KB + pwm_timer_pkg::CAP_FALL_FLAG_BIT]));
                capture_flag_reg[i] <= cap_irq_evt[i] | (capture_flag_reg[i]
                    & ~(cap_wr & wdata[KB + pwm_timer_pkg::CAP_FLAG_BIT]));
            end
        end

        // Dead zone: pair driven by even timer, odd output complementary
        assign dz_on = channel_control_reg[pwm_timer_pkg::CTL_DZ_BIT + PAIR];
        assign dz_len = prescale_control_reg[pwm_timer_pkg::DZ_POS + PAIR * 8 +: 8];
        always_comb begin
            if (!dz_on) begin
                target = raw_pwm[i];
            end else if (i % 2 == 0) begin
                target = raw_pwm[2 * PAIR];
            end else begin
                target = run[2 * PAIR] && !raw_pwm[2 * PAIR];
            end
        end

        // Delay counted in even-timer ticks; falling edges pass at once
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                dz_cnt_reg[i] <= 8'h00;
                out_reg[i] <= 1'b0;
            end else if (!target) begin
                dz_cnt_reg[i] <= 8'h00;
                out_reg[i] <= 1'b0;
            end else if (!dz_on || dz_cnt_reg[i] >= dz_len) begin
                out_reg[i] <= 1'b1;
            end else if (tick[2 * PAIR]) begin
                dz_cnt_reg[i] <= dz_cnt_reg[i] + 8'h01;
            end
        end

        assign pwm_out[i] = out_reg[i] ^ channel_control_reg[CB + pwm_timer_pkg::CTL_INV_BIT];
    end

    assign pwm_oe = pin_output_enable_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Period flags and merged interrupt
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            period_flag_reg <= 4'h0;
        end else begin
            period_flag_reg <= zero_evt | (period_flag_reg & ~({4{wr_en
                && addr == pwm_timer_pkg::INT_FLAG_OFF}} & wdata[3:0]));
        end
    end

    // Each channel shares one source between its PWM and capture use
    assign group_a_interrupt = |((period_flag_reg & interrupt_enable_set_reg)
        | capture_flag_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Read mux, data valid the cycle after the strobe
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (addr)
            pwm_timer_pkg::PRESCALE_OFF: rdata_next = prescale_control_reg;
            pwm_timer_pkg::DIVIDER_OFF: rdata_next = divider_select_reg;
            pwm_timer_pkg::CONTROL_OFF: rdata_next = channel_control_reg;
            pwm_timer_pkg::INT_ENABLE_OFF: rdata_next[3:0] = interrupt_enable_set_reg;
            pwm_timer_pkg::INT_FLAG_OFF: rdata_next[3:0] = period_flag_reg;
            pwm_timer_pkg::CAPEN_OFF: rdata_next[3:0] = capture_input_enable_reg;
            pwm_timer_pkg::OUTEN_OFF: rdata_next[3:0] = pin_output_enable_reg;
            default: ;
        endcase
        for (int c = 0; c < pwm_timer_pkg::NUM_CH; c++) begin
            if (addr == ch_addr(c, pwm_timer_pkg::PERIOD_SUB)) begin
                rdata_next[15:0] = period_reload_value_reg[c];
            end
            if (addr == ch_addr(c, pwm_timer_pkg::COMPARE_SUB)) begin
                rdata_next[15:0] = compare_value_reg[c];
            end
            if (addr == ch_addr(c, pwm_timer_pkg::READBACK_SUB)) begin
                rdata_next[15:0] = count_reg[c];
            end
            if (addr == latch_addr(c, 8'h00)) begin
                rdata_next[15:0] = rise_capture_latch_reg[c];
            end
            if (addr == latch_addr(c, pwm_timer_pkg::FALL_SUB)) begin
                rdata_next[15:0] = fall_capture_latch_reg[c];
            end
            if (addr == 8'(pwm_timer_pkg::CAPCTL_OFF
                + (c / 2) * pwm_timer_pkg::CAPCTL_STRIDE)) begin
                rdata_next[(c % 2) * 16 + pwm_timer_pkg::CAP_RISE_IE_BIT] = rise_ie_reg[c];
                rdata_next[(c % 2) * 16 + pwm_timer_pkg::CAP_FALL_IE_BIT] = fall_ie_reg[c];
                rdata_next[(c % 2) * 16 + pwm_timer_pkg::CAP_FLAG_BIT] = capture_flag_reg[c];
                rdata_next[(c % 2) * 16 + pwm_timer_pkg::CAP_RISE_FLAG_BIT] = rise_flag_reg[c];
                rdata_next[(c % 2) * 16 + pwm_timer_pkg::CAP_FALL_FLAG_BIT] = fall_flag_reg[c];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_en) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign rdata = rdata_reg;

endmodule

/* verif/cap_driver.sv */
// Far-side model: pin level seen by the capture inputs
module cap_driver (
    // Clock
    input wire logic clock,
    // Pins
    input wire logic [3:0] pwm_out,
    input wire logic [3:0] pwm_oe,
    output logic [3:0] cap_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ext_reg = 4'h0;
    // Driven pin shows the channel output, so capture sees the far-side level only on a released pin
    assign cap_in = (pwm_oe & pwm_out) | (~pwm_oe & ext_reg);
    // Only channels with the output released are ever given an edge
    task automatic set_level(input logic [3:0] v);
        @(posedge clock);
        ext_reg <= v;
    endtask
endmodule

/* verif/pwm_timer_sva.sv */
// Port-level assertions for the PWM timer with capture
module pwm_timer_sva (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    // Pins
    input wire logic [3:0] pwm_out,
    input wire logic [3:0] pwm_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_read_idle: assert property (!rd_en |=> rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_unmapped_read: assert property (rd_en && addr == 8'h48 |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    a_count_upper: assert property (rd_en && (addr == 8'h14 || addr == 8'h20
        || addr == 8'h2C || addr == 8'h38) |=> rdata[31:16] == 16'h0)
        else $error("counter upper bits not zero");
    a_period_echo: assert property (wr_en && addr == pwm_timer_pkg::CH_BASE_OFF ##1
        rd_en && addr == pwm_timer_pkg::CH_BASE_OFF
        |=> rdata == {16'h0, $past(wdata[15:0], 2)})
        else $error("period buffer lost written value");
    a_prescale_echo: assert property (wr_en && addr == pwm_timer_pkg::PRESCALE_OFF ##1
        rd_en && addr == pwm_timer_pkg::PRESCALE_OFF |=> rdata == $past(wdata, 2))
        else $error("prescale value lost");
    a_oe_follow: assert property (wr_en && addr == pwm_timer_pkg::OUTEN_OFF ##1
        !(wr_en && addr == pwm_timer_pkg::OUTEN_OFF) |=> pwm_oe == $past(wdata[3:0], 2))
        else $error("output enable not applied");
    a_oe_hold: assert property ($changed(pwm_oe) |-> $past(wr_en && addr == 8'h7C)
        || $past(wr_en && addr == 8'h7C, 2))
        else $error("output enable changed without a write");
    // Any control write with all run and invert bits clear must idle every pin
    a_stop_output: assert property (wr_en && addr == pwm_timer_pkg::CONTROL_OFF
        && (wdata & 32'h0505_0505) == 32'h0
        ##1 !(wr_en && addr == pwm_timer_pkg::CONTROL_OFF) |=> pwm_out == 4'h0)
        else $error("output still active after stop");
endmodule

bind pwm_timer_with_capture pwm_timer_sva i_sva (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pwm_out(pwm_out),
    .pwm_oe(pwm_oe));

/* verif/tb_pwm_timer_with_capture.sv */
// Self-checking bench for the PWM timer with capture
module tb_pwm_timer_with_capture;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst, wr_en, rd_en, group_a_interrupt;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, rv, rv2;
    logic [3:0] pwm_out, pwm_oe, cap_in;
    logic [7:0] raddr[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h40, 8'h50, 8'h7C};
    int errors, compares, n, c, hi, lo;

    pwm_timer_with_capture i_pwm_timer_with_capture (.clock(clock), .rst(rst), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pwm_out(pwm_out),
        .pwm_oe(pwm_oe), .cap_in(cap_in), .group_a_interrupt(group_a_interrupt));
    cap_driver i_cap (.clock(clock), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .cap_in(cap_in));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // Clocks spanned by a number of timer ticks, one tick every second clock
    function automatic int clocks(input int ticks);
        return 2 * ticks;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        // Strobe lowered in this step by a previous write: let an edge pass
        if (wr_en) @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        @(posedge clock);
        d = rdata;
    endtask

    task automatic rd_check(input string name, input logic [7:0] a, input logic [31:0] exp);
        rd(a, rv);
        check(name, exp, rv);
    endtask

    // Bounded so a stuck output cannot hang the run
    task automatic run_while(input logic v, output int cnt);
        cnt = 0;
        while (pwm_out[0] === v && cnt < 400) begin
            @(posedge clock);
            cnt++;
        end
    endtask

    task automatic end_of_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clock);
        errors++;
        end_of_test();
    end

    initial begin
        void'($urandom(54265));
        rst = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        foreach (raddr[i]) rd_check("reset_value", raddr[i], 32'h0);
        wr(8'h48, 32'hFFFF_FFFF);
        rd_check("unmapped", 8'h48, 32'h0);
        $display("test reset done");
        // Each pair ticks every second clock, channel 0 and 1 dividers set to one, channels 2 and 3 to two
        wr(8'h04, 32'h0000_0044);
        wr(8'h00, 32'h0000_0101);
        rd_check("prescale", 8'h00, 32'h0000_0101);
        wr(8'h08, 32'h0000_0008);
        wr(8'h40, 32'h0000_0001);
        wr(8'h7C, 32'h0000_0001);
        wr(8'h08, 32'h0000_0009);
        for (int i = 0; i < 4; i++) begin
            n = 2 + $urandom_range(7);
            c = (i == 3) ? n + $urandom_range(3) : $urandom_range(n - 1);
            wr(8'h10, c);
            wr(8'h0C, n);
            rd_check("period", 8'h0C, n);
            run_while(1'b1, hi);
            run_while(1'b0, lo);
            run_while(1'b1, hi);
            run_while(1'b0, lo);
            run_while(1'b1, hi);
            run_while(1'b0, lo);
            if (c >= n) begin
                check("always_high", 400, hi);
            end else begin
                check("high_width", clocks(c + 1), hi);
                check("low_width", clocks(n - c), lo);
            end
        end
        rd(8'h14, rv);
        check("readback_range", 1, rv <= n);
        rd_check("period_flag", 8'h44, 32'h1);
        check("irq_raised", 1, group_a_interrupt);
        wr(8'h40, 32'h0);
        @(posedge clock);
        check("irq_masked", 0, group_a_interrupt);
        $display("test pwm done");
        wr(8'h08, 32'h0000_0008);
        rd(8'h14, rv);
        rd(8'h14, rv2);
        check("counter_hold", rv, rv2);
        check("stopped_out", 0, pwm_out[0]);
        wr(8'h08, 32'h0000_000C);
        @(posedge clock);
        check("inverted_idle", 1, pwm_out[0]);
        wr(8'h08, 32'h0000_0001);
        rd_check("mode_clear_period", 8'h0C, 32'h0);
        rd_check("mode_clear_compare", 8'h10, 32'h0);
        // The running count drains to zero first, then must stay there
        repeat (40) @(posedge clock);
        rd(8'h14, rv);
        rd(8'h14, rv2);
        check("zero_period_count", 0, rv);
        check("zero_period_hold", rv, rv2);
        wr(8'h10, 32'h1);
        wr(8'h0C, 32'h3);
        rd(8'h14, rv);
        check("oneshot_start", 1, rv >= 1 && rv <= 3);
        repeat (40) @(posedge clock);
        rd_check("oneshot_period", 8'h0C, 32'h0);
        rd_check("oneshot_compare", 8'h10, 32'h0);
        rd_check("oneshot_count", 8'h14, 32'h0);
        $display("test oneshot done");
        wr(8'h7C, 32'h0);
        wr(8'h78, 32'h2);
        wr(8'h50, 32'h0002_0000);
        wr(8'h08, 32'h0000_0900);
        wr(8'h18, 32'd20);
        repeat (30) @(posedge clock);
        i_cap.set_level(4'h2);
        repeat (4) @(posedge clock);
        rd(8'h20, rv);
        check("capture_reload", 1, rv >= 15 && rv <= 20);
        rd(8'h60, rv);
        check("rise_latch", 1, rv <= 20);
        rd(8'h50, rv);
        check("rise_flag", 1, rv[22]);
        check("capture_irq", 1, group_a_interrupt);
        i_cap.set_level(4'h0);
        repeat (6) @(posedge clock);
        rd(8'h64, rv);
        check("fall_latch", 1, rv >= 12 && rv <= 16);
        wr(8'h50, 32'h00D0_0000);
        @(posedge clock);
        check("capture_cleared", 0, group_a_interrupt);
        $display("test capture done");
        end_of_test();
    end
endmodule
